// file: pkg/gpio_pkg.sv
package gpio_pkg;
    localparam logic [7:0] ADDR_PORT1_DATA = 8'h20;
    localparam logic [7:0] ADDR_PORT1_DIRECTION = 8'h21;
    localparam logic [7:0] ADDR_PORT1_PULLUP_SELECT = 8'h22;
    localparam logic [7:0] ADDR_PORT1_ANALOG_DIGITAL_SELECT = 8'h23;
    localparam logic [7:0] ADDR_PORT3_DATA = 8'h28;
    localparam logic [7:0] ADDR_PORT3_DIRECTION = 8'h29;
    localparam logic [7:0] ADDR_PORT3_PULLUP_SELECT = 8'h2A;
    localparam logic [7:0] ADDR_PORT3_MODE_CONTROL = 8'h2B;
    localparam logic [7:0] ADDR_PORT2_OPEN_DRAIN_CONTROL = 8'h37;
    localparam logic [7:0] ADDR_PORT2_MODE_CONTROL = 8'h27;
    localparam int MODULATOR_ENABLE_BIT = 4;
    localparam int PROG_COUNTER_ENABLE_BIT = 4;
    localparam int TRIG_HI_LSB = 2;
    localparam int TRIG_LO_LSB = 0;
    localparam int OPEN_DRAIN_LSB = 3;
    localparam int PORT2_MODULATOR_PIN = 2;
    localparam logic [7:0] PORT1_DIGITAL_ONLY_MASK = 8'hC0;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [1:0] OPEN_DRAIN_RESET = 2'h3;
    localparam logic [3:0] PORT3_MASK = 4'hF;
    typedef enum logic [1:0] {
        TRIG_FALL = 2'b00,
        TRIG_RISE = 2'b01,
        TRIG_ANY_A = 2'b10,
        TRIG_ANY_B = 2'b11
    } trig_mode_t;
endpackage : gpio_pkg

// file: pkg/edge_if.sv
`timescale 1ns/1ns
interface edge_if;
    logic pin_level;
    logic [1:0] mode;
    logic event_pulse;
    modport detector (input pin_level, input mode, output event_pulse);
    modport owner (output pin_level, output mode, input event_pulse);
endinterface : edge_if

// file: hw/edge_detect.sv
`timescale 1ns/1ns
module edge_detect
    import gpio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    edge_if.detector port
);
    logic sync_a;
    logic sync_b;
    logic prev;
    logic rise;
    logic fall;

    // Three stages; first stage only feeds the second
    always_ff @(posedge sys_clk) begin
        // Stages load the idle pin level so no false edge follows reset
        if (srst) begin
            sync_a <= port.pin_level;
            sync_b <= port.pin_level;
            prev <= port.pin_level;
        end else begin
            sync_a <= port.pin_level;
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end

    assign rise = sync_b & ~prev;
    assign fall = ~sync_b & prev;

    always_comb begin
        case (trig_mode_t'(port.mode))
            TRIG_FALL: port.event_pulse = fall;
            TRIG_RISE: port.event_pulse = rise;
            TRIG_ANY_A, TRIG_ANY_B: port.event_pulse = rise | fall;
            default: port.event_pulse = 1'b0;
        endcase
    end
endmodule : edge_detect

// file: hw/gpio_ports.sv
`timescale 1ns/1ns
// Overview of operation
// - Modulator enable hands port2 bit2 to modulator
// - Port2 mode holds two trigger fields
// - Port3 mode bits 3-2 trigger port3 bit1
// - Port3 mode bits 1-0 trigger port3 bit0
// - Mode 00 means falling edge
// - Mode 01 means rising edge
// - Modes 10 and 11 mean any edge
// - Port3 mode bit4 enables programmable counter
// - Port3 has four data bits
// - Direction bit one drives pin
// - Pull-up on undriven input reads one
// - Open-drain bits for port2 bits 4,3
// - Open-drain bits reset to one
// - Port1 digital read gated by select
// - Data write loads held output latch
// - Port1 has eight direction-controlled pins
// - Input read returns external pin level
// - Port1 bits 6,7 digital only
// - Events pass only when enabled
module gpio_ports
    import gpio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [7:0] rdata,
    input wire logic [7:0] port1_in,
    output logic [7:0] port1_out,
    output logic [7:0] port1_oe,
    output logic [7:0] port1_pullup_en,
    output logic [7:0] port1_analog_en,
    input wire logic [7:0] port2_in,
    input wire logic [7:0] port2_latch,
    input wire logic [7:0] port2_direction,
    input wire logic modulator_out,
    output logic [4:0] port2_out,
    output logic [4:0] port2_oe,
    input wire logic [3:0] port3_in,
    output logic [3:0] port3_out,
    output logic [3:0] port3_oe,
    output logic [3:0] port3_pullup_en,
    input wire logic [3:0] ext_irq_enable,
    output logic [3:0] ext_irq_request,
    output logic modulator_enable,
    output logic prog_counter_enable
);
    logic [7:0] port1_data;
    logic [7:0] port1_direction;
    logic [7:0] port1_pullup_select;
    logic [7:0] port1_analog_digital_select;
    logic [3:0] port3_data;
    logic [3:0] port3_direction;
    logic [3:0] port3_pullup_select;
    logic [4:0] port3_mode_control;
    logic [1:0] port2_open_drain_select;
    logic [4:0] port2_mode_control;
    logic [7:0] next_rdata;
    logic [7:0] port1_read;
    logic [3:0] port3_read;
    logic [3:0] irq_event;
    logic [4:0] next_port2_out;
    logic [4:0] next_port2_oe;

    edge_if e0();
    edge_if e1();
    edge_if e2();
    edge_if e3();

    assign e0.pin_level = port2_in[0];
    assign e0.mode = port2_mode_control[TRIG_LO_LSB +: 2];
    assign e1.pin_level = port2_in[1];
    assign e1.mode = port2_mode_control[TRIG_HI_LSB +: 2];
    assign e2.pin_level = port3_in[0];
    assign e2.mode = port3_mode_control[TRIG_LO_LSB +: 2];
    assign e3.pin_level = port3_in[1];
    assign e3.mode = port3_mode_control[TRIG_HI_LSB +: 2];

    edge_detect u_e0 (.sys_clk(sys_clk), .srst(srst), .port(e0.detector));
    edge_detect u_e1 (.sys_clk(sys_clk), .srst(srst), .port(e1.detector));
    edge_detect u_e2 (.sys_clk(sys_clk), .srst(srst), .port(e2.detector));
    edge_detect u_e3 (.sys_clk(sys_clk), .srst(srst), .port(e3.detector));

    assign irq_event = {e3.event_pulse, e2.event_pulse, e1.event_pulse, e0.event_pulse};

    // Data latches have no reset value; zero chosen so pins start defined
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port1_data <= RESET_ZERO;
            port3_data <= RESET_ZERO[3:0];
        end else if (wr_strobe) begin
            if (addr == ADDR_PORT1_DATA) begin
                port1_data <= wdata;
            end
            if (addr == ADDR_PORT3_DATA) begin
                port3_data <= wdata[3:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port1_direction <= RESET_ZERO;
            port1_pullup_select <= RESET_ZERO;
            port1_analog_digital_select <= RESET_ZERO;
        end else if (wr_strobe) begin
            if (addr == ADDR_PORT1_DIRECTION) begin
                port1_direction <= wdata;
            end
            if (addr == ADDR_PORT1_PULLUP_SELECT) begin
                port1_pullup_select <= wdata;
            end
            if (addr == ADDR_PORT1_ANALOG_DIGITAL_SELECT) begin
                port1_analog_digital_select <= wdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port3_direction <= RESET_ZERO[3:0];
            port3_pullup_select <= RESET_ZERO[3:0];
            port3_mode_control <= RESET_ZERO[4:0];
            port2_mode_control <= RESET_ZERO[4:0];
            port2_open_drain_select <= OPEN_DRAIN_RESET;
        end else if (wr_strobe) begin
            if (addr == ADDR_PORT3_DIRECTION) begin
                port3_direction <= wdata[3:0];
            end
            if (addr == ADDR_PORT3_PULLUP_SELECT) begin
                port3_pullup_select <= wdata[3:0];
            end
            if (addr == ADDR_PORT3_MODE_CONTROL) begin
                port3_mode_control <= wdata[4:0];
            end
            if (addr == ADDR_PORT2_MODE_CONTROL) begin
                port2_mode_control <= wdata[4:0];
            end
            if (addr == ADDR_PORT2_OPEN_DRAIN_CONTROL) begin
                port2_open_drain_select <= wdata[OPEN_DRAIN_LSB +: 2];
            end
        end
    end

    // Port3 pins are read raw, port1 pins 0-5 gated by digital select and pins 6,7 read raw; pull-up makes an undriven pin arrive as one
    always_comb begin
        port1_read = port1_in & (port1_analog_digital_select | PORT1_DIGITAL_ONLY_MASK);
        port3_read = port3_in;
    end

    always_comb begin
        case (addr)
            ADDR_PORT1_DATA: next_rdata = port1_read;
            ADDR_PORT1_DIRECTION: next_rdata = port1_direction;
            ADDR_PORT1_PULLUP_SELECT: next_rdata = port1_pullup_select;
            ADDR_PORT1_ANALOG_DIGITAL_SELECT: next_rdata = port1_analog_digital_select;
            ADDR_PORT3_DATA: next_rdata = {4'h0, port3_read};
            ADDR_PORT3_DIRECTION: next_rdata = {4'h0, port3_direction};
            ADDR_PORT3_PULLUP_SELECT: next_rdata = {4'h0, port3_pullup_select};
            ADDR_PORT3_MODE_CONTROL: next_rdata = {3'h0, port3_mode_control};
            ADDR_PORT2_MODE_CONTROL: next_rdata = {3'h0, port2_mode_control};
            ADDR_PORT2_OPEN_DRAIN_CONTROL: next_rdata = {3'h0, port2_open_drain_select, 3'h0};
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data valid only the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (rd_strobe) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 8'h00;
        end
    end

    // Port2 pins 0-4 are shaped here; data and direction live elsewhere
    always_comb begin
        next_port2_out = port2_latch[4:0];
        next_port2_oe = port2_direction[4:0];
        if (port2_mode_control[MODULATOR_ENABLE_BIT]) begin
            next_port2_out[PORT2_MODULATOR_PIN] = modulator_out;
            next_port2_oe[PORT2_MODULATOR_PIN] = 1'b1;
        end
        // Open drain only pulls low, releases for a one
        if (port2_open_drain_select[0]) begin
            next_port2_out[3] = 1'b0;
            next_port2_oe[3] = port2_direction[3] & ~port2_latch[3];
        end
        if (port2_open_drain_select[1]) begin
            next_port2_out[4] = 1'b0;
            next_port2_oe[4] = port2_direction[4] & ~port2_latch[4];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port1_out <= 8'h00;
            port1_oe <= 8'h00;
            port1_pullup_en <= 8'h00;
            port1_analog_en <= 8'h00;
            port3_out <= 4'h0;
            port3_oe <= 4'h0;
            port3_pullup_en <= 4'h0;
            port2_out <= 5'h00;
            port2_oe <= 5'h00;
            modulator_enable <= 1'b0;
            prog_counter_enable <= 1'b0;
        end else begin
            port1_out <= port1_data;
            port1_oe <= port1_direction;
            port1_pullup_en <= port1_pullup_select & ~port1_direction;
            port1_analog_en <= ~port1_analog_digital_select & ~PORT1_DIGITAL_ONLY_MASK;
            port3_out <= port3_data;
            port3_oe <= port3_direction & PORT3_MASK;
            port3_pullup_en <= port3_pullup_select & ~port3_direction;
            port2_out <= next_port2_out;
            port2_oe <= next_port2_oe;
            modulator_enable <= port2_mode_control[MODULATOR_ENABLE_BIT];
            prog_counter_enable <= port3_mode_control[PROG_COUNTER_ENABLE_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ext_irq_request <= 4'h0;
        end else begin
            ext_irq_request <= irq_event & ext_irq_enable;
        end
    end
endmodule : gpio_ports

// file: testbench/gpio_chk.sv
`timescale 1ns/1ns
module gpio_chk
    import gpio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [7:0] rdata,
    input wire logic [7:0] port1_out,
    input wire logic [7:0] port1_oe,
    input wire logic [7:0] port1_analog_en,
    input wire logic [7:0] port2_in,
    input wire logic modulator_out,
    input wire logic [4:0] port2_out,
    input wire logic [4:0] port2_oe,
    input wire logic [3:0] port3_in,
    input wire logic [3:0] ext_irq_enable,
    input wire logic [3:0] ext_irq_request,
    input wire logic modulator_enable,
    input wire logic prog_counter_enable
);
    logic [7:0] wd1;
    logic [7:0] wd2;
    logic wr_p1;
    logic rd_p3;
    logic [3:0] src;
    assign wr_p1 = wr_strobe && addr == ADDR_PORT1_DATA;
    assign rd_p3 = rd_strobe && addr == ADDR_PORT3_DATA;
    assign src = {port3_in[1:0], port2_in[1:0]};
    // Write data delayed to meet the two-edge output latency
    always_ff @(posedge sys_clk) begin
        wd1 <= wdata;
        wd2 <= wd1;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    p1_write_a: assert property (wr_p1 |-> ##2 port1_out == wd2)
        else $error("port1 output not loaded");
    p1_hold_a: assert property (!$past(wr_p1, 2) |-> $stable(port1_out))
        else $error("port1 output moved");
    p1_dir_a: assert property (wr_strobe && addr == ADDR_PORT1_DIRECTION |-> ##2 port1_oe == wd2)
        else $error("port1 direction wrong");
    pce_a: assert property (wr_strobe && addr == ADDR_PORT3_MODE_CONTROL |-> ##2 prog_counter_enable == wd2[4])
        else $error("counter enable wrong");
    mod_pin_a: assert property (modulator_enable [*2] |-> port2_oe[2] && port2_out[2] == $past(modulator_out))
        else $error("modulator pin wrong");
    digital_only_a: assert property (port1_analog_en[7:6] == 2'b00)
        else $error("port1 upper pins analog");
    p3_upper_a: assert property ($past(rd_p3) |-> rdata[7:4] == 4'h0)
        else $error("port3 upper bits set");
    irq_cause_a: assert property (ext_irq_request != 4'h0 |-> (ext_irq_request & ~($past(src, 3) ^ $past(src, 4))) == 4'h0)
        else $error("request without pin change");
    irq_gate_a: assert property ((ext_irq_request & ~$past(ext_irq_enable)) == 4'h0)
        else $error("request while disabled");
endmodule : gpio_chk
bind gpio_ports gpio_chk i_gpio_chk (.*);

// file: testbench/ext_pins.sv
`timescale 1ns/1ns
module ext_pins #(
    parameter int W = 8
) (
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pu,
    input wire logic [W-1:0] drv,
    input wire logic [W-1:0] drv_en,
    output logic [W-1:0] lvl
);
    // Floating without pull-up shows inverse latch, so no stale level passes
    assign lvl = (oe & out) | (~oe & drv_en & drv) | (~oe & ~drv_en & (pu | ~out));
endmodule : ext_pins

// file: testbench/gpio_ports_tb.sv
`timescale 1ns/1ns
module gpio_ports_tb;
    import gpio_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic wr_strobe = 1'b0, rd_strobe = 1'b0, modulator_out = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, port2_in = 8'h00, port2_latch = 8'h00;
    logic [7:0] port2_direction = 8'h00, drv1 = 8'h00, drv1_en = 8'h00, pcnt = 8'h00;
    logic [3:0] ext_irq_enable = 4'h0, drv3 = 4'h0, drv3_en = 4'h0;
    logic [7:0] rdata, port1_in, port1_out, port1_oe, port1_pullup_en, port1_analog_en;
    logic [4:0] port2_out, port2_oe;
    logic [3:0] port3_in, port3_out, port3_oe, port3_pullup_en, ext_irq_request;
    logic modulator_enable, prog_counter_enable;
    int fails = 0, checks = 0;
    logic [7:0] ra [8] = '{8'h21, 8'h22, 8'h23, 8'h29, 8'h2A, 8'h2B, 8'h37, 8'h30};
    gpio_ports i_gpio_ports (.*);
    ext_pins #(.W(8)) i_ext_pins (.out(port1_out), .oe(port1_oe), .pu(port1_pullup_en),
        .drv(drv1), .drv_en(drv1_en), .lvl(port1_in));
    ext_pins #(.W(4)) i_ext_pins_p3 (.out(port3_out), .oe(port3_oe), .pu(port3_pullup_en),
        .drv(drv3), .drv_en(drv3_en), .lvl(port3_in));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // Two-bit count per source; edge_chk takes its deltas field by field
    always @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            pcnt[2*i +: 2] <= pcnt[2*i +: 2] + 2'(ext_irq_request[i]);
        end
    end
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge sys_clk);
        wr_strobe <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge sys_clk);
        rd_strobe <= 1'b0;
        @(negedge sys_clk);
        chk("rdata", rdata, e);
    endtask : rd
    task settle;
        repeat (4) @(negedge sys_clk);
    endtask : settle
    task edge_chk(input logic v, input logic [7:0] e);
        logic [7:0] base;
        logic [7:0] delta;
        base = pcnt;
        @(posedge sys_clk);
        port2_in[1:0] <= {2{v}};
        drv3[1:0] <= {2{v}};
        repeat (8) @(negedge sys_clk);
        // A plain subtraction would borrow across fields when one wraps
        for (int i = 0; i < 4; i++) begin
            delta[2*i +: 2] = pcnt[2*i +: 2] - base[2*i +: 2];
        end
        chk("irq count", delta, e);
    endtask : edge_chk
    task tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #1000000;
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], i == 6 ? 8'h18 : 8'h00);
        end
        $display("reset values done");
        wr(ADDR_PORT1_DIRECTION, 8'hFF);
        wr(ADDR_PORT1_DATA, 8'hA5);
        settle();
        chk("port1_out", port1_out, 8'hA5);
        chk("port1_oe", port1_oe, 8'hFF);
        rd(ADDR_PORT1_DATA, 8'h80);
        wr(ADDR_PORT1_ANALOG_DIGITAL_SELECT, 8'hFF);
        wr(ADDR_PORT1_DIRECTION, 8'h00);
        drv1 <= 8'h3C;
        drv1_en <= 8'hFF;
        settle();
        chk("port1_analog_en", port1_analog_en, 8'h00);
        rd(ADDR_PORT1_DATA, 8'h3C);
        wr(ADDR_PORT1_PULLUP_SELECT, 8'hFF);
        drv1_en <= 8'h00;
        settle();
        chk("port1_pullup_en", port1_pullup_en, 8'hFF);
        rd(ADDR_PORT1_DATA, 8'hFF);
        chk("port1_out", port1_out, 8'hA5);
        $display("port1 done");
        wr(ADDR_PORT3_DIRECTION, 8'hFF);
        wr(ADDR_PORT3_DATA, 8'hF6);
        settle();
        chk("port3_out", {4'h0, port3_out}, 8'h06);
        chk("port3_oe", {4'h0, port3_oe}, 8'h0F);
        rd(ADDR_PORT3_DATA, 8'h06);
        rd(ADDR_PORT3_DIRECTION, 8'h0F);
        wr(ADDR_PORT2_MODE_CONTROL, 8'h10);
        modulator_out <= 1'b1;
        wr(ADDR_PORT3_MODE_CONTROL, 8'h10);
        settle();
        chk("mode enables", {6'h0, modulator_enable, prog_counter_enable}, 8'h03);
        chk("modulator pin", {6'h0, port2_oe[2], port2_out[2]}, 8'h03);
        wr(ADDR_PORT2_MODE_CONTROL, 8'h00);
        port2_direction <= 8'hFF;
        port2_latch <= 8'hFB;
        settle();
        chk("gpio pin", {6'h0, port2_oe[2], port2_out[2]}, 8'h02);
        chk("open drain", {6'h0, port2_oe[4:3]}, 8'h00);
        wr(ADDR_PORT2_OPEN_DRAIN_CONTROL, 8'h00);
        settle();
        chk("push pull", {4'h0, port2_oe[4:3], port2_out[4:3]}, 8'h0F);
        $display("modes done");
        wr(ADDR_PORT3_DIRECTION, 8'h00);
        drv3_en <= 4'h3;
        ext_irq_enable <= 4'hF;
        settle();
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_PORT2_MODE_CONTROL, 8'(m * 5));
            wr(ADDR_PORT3_MODE_CONTROL, 8'(m * 5));
            settle();
            edge_chk(1'b1, m != 0 ? 8'h55 : 8'h00);
            edge_chk(1'b0, m != 1 ? 8'h55 : 8'h00);
        end
        @(posedge sys_clk);
        ext_irq_enable <= 4'h0;
        settle();
        edge_chk(1'b1, 8'h00);
        wr(ADDR_PORT3_PULLUP_SELECT, 8'hFF);
        settle();
        chk("port3_pullup_en", {4'h0, port3_pullup_en}, 8'h0F);
        rd(ADDR_PORT3_DATA, 8'h0F);
        $display("interrupts done");
        tally_and_finish();
    end
endmodule : gpio_ports_tb
